// *** hdl/synth_serial_latch_control.sv ***
`timescale 1ns/10ps
`include "synth_latch_consts.svh"
module synth_serial_latch_control
    import synth_latch_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic        CLK_EN,
    input  wire logic        SER_DATA,
    input  wire logic        SER_CLK,
    input  wire logic        WORD_LATCH_STROBE,
    input  wire logic        POWER_ENABLE,
    input  wire logic        PD_TICK,
    output logic [20:0]      REF_LATCH,
    output logic [20:0]      FEED_LATCH,
    output logic [20:0]      FUNC_LATCH,
    output logic             COUNTER_RESET,
    output logic             PUMP_HIGHZ,
    output logic             POWERDOWN,
    output logic             HIGH_GAIN,
    output logic             QUARTER_RATIO,
    output logic             DAMPING_SWITCH_OUTPUT,
    output logic             DAMPING_SWITCH_OE,
    output logic [12:0]      MAIN_COUNT,
    output logic [4:0]       SWALLOW_COUNT,
    output logic [13:0]      REF_RATIO,
    output logic             LOCK_PRECISION
);
    serial_pins_s sync_w;        // Synchronised pins
    logic         sclk_d_r;      // Previous serial clock level
    logic         strobe_d_r;    // Previous strobe level
    word_t        shift_r;       // Input shift register
    word_t        shift_nxt;
    word_t        ref_r;         // Reference divider latch
    word_t        feed_r;        // Feedback divider latch
    word_t        func_r;        // Function latch
    logic         init_seen_r;   // Armed by init load for one feedback
    logic         go_r;          // Gain boost trigger
    logic         rst_pulse_r;   // Internal counter reset pulse
    logic         pd_sync_r;     // Synchronous powerdown state
    logic         pwr_d_r;       // Previous power enable
    logic         expire_w;
    gain_mode_e   mode_w;

    // Pins arrive from the host domain; three stages each
    pin_sync3 u_sync_data (.clk(CORE_CLK), .rst_n(RSTN), .ce(CLK_EN),
        .din(SER_DATA), .dout(sync_w.data));
    pin_sync3 u_sync_sclk (.clk(CORE_CLK), .rst_n(RSTN), .ce(CLK_EN),
        .din(SER_CLK), .dout(sync_w.sclk));
    pin_sync3 u_sync_strb (.clk(CORE_CLK), .rst_n(RSTN), .ce(CLK_EN),
        .din(WORD_LATCH_STROBE), .dout(sync_w.strobe));
    logic pwr_w;
    pin_sync3 u_sync_pwr (.clk(CORE_CLK), .rst_n(RSTN), .ce(CLK_EN),
        .din(POWER_ENABLE), .dout(pwr_w));

    // Edge detection on the filtered levels
    logic sclk_rise_w;
    logic strobe_rise_w;
    assign sclk_rise_w   = sync_w.sclk && !sclk_d_r;
    assign strobe_rise_w = sync_w.strobe && !strobe_d_r;

    // MSB arrives first, so shift toward the top
    assign shift_nxt = {shift_r[19:0], sync_w.data};

    // Destination decode from the last two bits received
    logic [1:0] dest_w;
    logic       ld_ref_w;
    logic       ld_feed_w;
    logic       ld_func_w;
    logic       ld_init_w;
    assign dest_w    = shift_r[1:0];
    assign ld_ref_w  = strobe_rise_w && dest_w == `DEST_REF;
    assign ld_feed_w = strobe_rise_w && dest_w == `DEST_FEED;
    assign ld_func_w = strobe_rise_w && dest_w == `DEST_FUNC;
    assign ld_init_w = strobe_rise_w && dest_w == `DEST_INIT;

    // Reset pulse: init load, or first feedback word after one
    logic pulse_req_w;
    assign pulse_req_w = ld_init_w || (ld_feed_w && init_seen_r);

    // Gain decode from function bits 8..10
    logic [2:0] fmode_w;
    assign fmode_w = func_r[`F_MODE_LO+2:`F_MODE_LO];
    always_comb begin
        mode_w = GAIN_OFF;
        if (fmode_w[0] && go_r) begin
            case ({fmode_w[1], fmode_w[2]})
                2'h0:    mode_w = GAIN_FULL_HOLD;
                2'h1:    mode_w = GAIN_FULL_TIMED;
                2'h2:    mode_w = GAIN_QTR_HOLD;
                default: mode_w = GAIN_QTR_TIMED;
            endcase
        end
    end
    logic timed_w;
    assign timed_w = mode_w == GAIN_FULL_TIMED || mode_w == GAIN_QTR_TIMED;

    // Timeout counter
    gain_timeout u_tmo (
        .clk     (CORE_CLK),
        .rst_n   (RSTN),
        .ce      (CLK_EN),
        .reload  (rst_pulse_r || ld_feed_w),
        .run     (timed_w),
        .pd_tick (PD_TICK),
        .setting (func_r[`F_TMO_LO+3:`F_TMO_LO]),
        .expire  (expire_w)
    );

    // Edge history and shift register
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sclk_d_r   <= 1'b0;
            strobe_d_r <= 1'b0;
            pwr_d_r    <= 1'b0;
            shift_r    <= `LATCH_RST;
        end else if (CLK_EN) begin
            sclk_d_r   <= sync_w.sclk;
            strobe_d_r <= sync_w.strobe;
            pwr_d_r    <= pwr_w;
            if (sclk_rise_w) begin
                shift_r <= shift_nxt;
            end
        end
    end

    // Latches load regardless of power enable and are never cleared by it
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ref_r  <= `LATCH_RST;
            feed_r <= `LATCH_RST;
            func_r <= `LATCH_RST;
        end else if (CLK_EN) begin
            if (ld_ref_w) begin
                ref_r <= shift_r;
            end
            if (ld_feed_w) begin
                feed_r <= shift_r;
            end
            if (ld_func_w || ld_init_w) begin
                func_r <= shift_r;
            end
        end
    end

    // Arm flag, trigger bit and reset pulse
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            init_seen_r <= 1'b0;
            go_r        <= 1'b0;
            rst_pulse_r <= 1'b0;
        end else if (CLK_EN) begin
            rst_pulse_r <= pulse_req_w;
            if (ld_init_w) begin
                init_seen_r <= 1'b1;
            end else if (ld_feed_w) begin
                init_seen_r <= 1'b0;
            end
            // A new feedback word wins over a same-cycle timeout
            if (ld_feed_w) begin
                go_r <= shift_r[`N_GO];
            end else if (expire_w && timed_w) begin
                go_r <= 1'b0;
            end
        end
    end

    // Synchronous powerdown; it ends once either powerdown bit is cleared
    logic pd_start_w;
    assign pd_start_w = rst_pulse_r && pwr_w && func_r[`F_PD_A]
                        && func_r[`F_PD_B] && !func_r[`F_HOLD];
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pd_sync_r <= 1'b0;
        end else if (CLK_EN) begin
            if (pd_start_w) begin
                pd_sync_r <= 1'b1;
            end else if (!(func_r[`F_PD_A] && func_r[`F_PD_B])) begin
                pd_sync_r <= 1'b0;
            end
        end
    end

    // Counter reset: pulse, hold bit, power enable low, or re-enable edge
    logic pwr_rise_w;
    assign pwr_rise_w = pwr_w && !pwr_d_r;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            COUNTER_RESET <= 1'b1;
            PUMP_HIGHZ    <= 1'b1;
            POWERDOWN     <= 1'b1;
        end else if (CLK_EN) begin
            // Hold cleared drops the reset, so both counters restart together
            COUNTER_RESET <= rst_pulse_r || func_r[`F_HOLD]
                             || !pwr_w || pwr_rise_w;
            PUMP_HIGHZ    <= rst_pulse_r || func_r[`F_HOLD];
            POWERDOWN     <= !pwr_w || pd_sync_r;
        end
    end

    // Gain, damping switch and field outputs
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            HIGH_GAIN             <= 1'b0;
            QUARTER_RATIO         <= 1'b0;
            DAMPING_SWITCH_OUTPUT <= 1'b0;
            DAMPING_SWITCH_OE     <= 1'b0;
        end else if (CLK_EN) begin
            if (!fmode_w[0]) begin
                HIGH_GAIN             <= go_r;
                QUARTER_RATIO         <= 1'b0;
                DAMPING_SWITCH_OUTPUT <= fmode_w[1];
                DAMPING_SWITCH_OE     <= 1'b1;
            end else begin
                HIGH_GAIN             <= mode_w != GAIN_OFF;
                QUARTER_RATIO         <= mode_w == GAIN_QTR_HOLD
                                         || mode_w == GAIN_QTR_TIMED;
                DAMPING_SWITCH_OUTPUT <= 1'b0;
                DAMPING_SWITCH_OE     <= mode_w != GAIN_OFF;
            end
        end
    end

    assign REF_LATCH      = ref_r;
    assign FEED_LATCH     = feed_r;
    assign FUNC_LATCH     = func_r;
    // Field k sits one bit above its number, past the select pair
    assign MAIN_COUNT     = feed_r[19:7];
    assign SWALLOW_COUNT  = feed_r[6:2];
    assign REF_RATIO      = ref_r[15:2];
    assign LOCK_PRECISION = ref_r[`R_LOCKP];

    // Assertions
    a_init_pulse: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        CLK_EN && ld_init_w |=> rst_pulse_r)
        else $error("init load gave no reset pulse");
    a_func_load: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        CLK_EN && ld_func_w |=> func_r == $past(shift_r))
        else $error("function latch not loaded");
    a_feed_once: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        CLK_EN && ld_feed_w && !init_seen_r |=> !rst_pulse_r)
        else $error("spurious feedback reset pulse");
    a_feed_first: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        CLK_EN && ld_feed_w && init_seen_r |=> rst_pulse_r)
        else $error("first feedback word missed reset");
    a_hold_reset: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        CLK_EN && func_r[`F_HOLD] |=> COUNTER_RESET && PUMP_HIGHZ)
        else $error("hold bit did not hold counters");
    a_hold_nopd: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        func_r[`F_HOLD] |-> !pd_start_w)
        else $error("powerdown started under hold");
    a_shift_msb: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        CLK_EN && sclk_rise_w |=> shift_r[0] == $past(sync_w.data))
        else $error("serial bit not shifted in");
    a_expire_go: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        CLK_EN && expire_w && timed_w && !ld_feed_w |=> !go_r)
        else $error("timeout did not clear trigger");
    a_damp_follow: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN)
        CLK_EN && !fmode_w[0] |=> DAMPING_SWITCH_OUTPUT == $past(fmode_w[1]))
        else $error("damping output not following bit 9");
    c_init_seq: cover property (@(posedge CORE_CLK) ld_init_w ##[1:1000]
        ld_feed_w);
    c_timeout: cover property (@(posedge CORE_CLK) expire_w && timed_w);
    c_quarter: cover property (@(posedge CORE_CLK) QUARTER_RATIO);
endmodule : synth_serial_latch_control

// *** inc/synth_latch_consts.svh ***
`ifndef SYNTH_LATCH_CONSTS_SVH
`define SYNTH_LATCH_CONSTS_SVH
// Word length and destination select codes
`define WORD_BITS        21
`define DEST_REF         2'h0
`define DEST_FEED        2'h2
`define DEST_FUNC        2'h1
`define DEST_INIT        2'h3
// Field k of a word sits at word bit k+1; the select pair fills bits 1..0
// Function latch field positions (word bits)
`define F_HOLD           2
`define F_PD_A           3
`define F_MODE_LO        9
`define F_TMO_LO         12
`define F_PD_B           19
// Feedback word field positions (word bits)
`define N_GO             20
// Reference word field positions (word bits)
`define R_LOCKP          20
// Reset values of the latches
`define LATCH_RST        21'h000000
// Timed mode codes in function bits 8..10 (bit 8 is LSB here)
`define FL_TIMED_BIT     2
`endif

// *** inc/synth_latch_pkg.sv ***
package synth_latch_pkg;
    // Three-wire serial pins after synchronisation
    typedef struct packed {
        logic data;
        logic sclk;
        logic strobe;
    } serial_pins_s;
    // High-gain mode decode
    typedef enum logic [2:0] {
        GAIN_OFF, GAIN_FULL_HOLD, GAIN_FULL_TIMED,
        GAIN_QTR_HOLD, GAIN_QTR_TIMED
    } gain_mode_e;
    typedef logic [20:0] word_t;
endpackage : synth_latch_pkg

// *** hdl/pin_sync3.sv ***
`timescale 1ns/10ps
// Three-stage synchroniser; a change counts when stages two and three agree
module pin_sync3 (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] st_r;   // Stage one is read only by stage two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= 3'h0;
            dout <= 1'b0;
        end else if (ce) begin
            st_r <= {st_r[1:0], din};
            if (st_r[1] == st_r[2]) begin
                dout <= st_r[2];
            end
        end
    end
endmodule : pin_sync3

// *** hdl/gain_timeout.sv ***
`timescale 1ns/10ps
// Timeout counter for timed high-gain mode, one step per comparison cycle
module gain_timeout (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       reload,  // Internal reset or new trigger
    input  wire logic       run,     // Timed mode with trigger set
    input  wire logic       pd_tick, // One pulse per comparison cycle
    input  wire logic [3:0] setting,
    output logic            expire   // One-cycle pulse
);
    logic [5:0] cnt_r;
    logic [5:0] load_w;
    // Setting k gives 4k+3 cycles
    assign load_w = {setting, 2'h3};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= 6'h00;
            expire <= 1'b0;
        end else if (ce) begin
            expire <= 1'b0;
            if (reload || !run) begin
                cnt_r <= load_w;
            end else if (pd_tick) begin
                if (cnt_r <= 6'h01) begin
                    expire <= 1'b1;
                    cnt_r  <= load_w;
                end else begin
                    cnt_r <= cnt_r - 6'h01;
                end
            end
        end
    end
endmodule : gain_timeout

// *** tb/serial_host_model.sv ***
`timescale 1ns/10ps
// Host side of the three-wire port; serial clock rests low between words
module serial_host_model (
    input  wire logic clk,
    output logic      ser_data,
    output logic      ser_clk,
    output logic      strobe
);
    // Idle levels before the first word
    initial begin
        ser_data = 1'b0;
        ser_clk  = 1'b0;
        strobe   = 1'b0;
    end

    // Shift one word, first bit on the wire is bit 20
    task automatic send(input logic [20:0] w);
        @(negedge clk);
        for (int i = 20; i >= 0; i--) begin
            // Data moves with the falling serial edge, 4 core cycles ahead
            ser_data = w[i];
            repeat (4) @(negedge clk);
            ser_clk = 1'b1;
            repeat (4) @(negedge clk);
            ser_clk = 1'b0;
        end
        // Released data line flips so a stale bit cannot look valid
        ser_data = ~ser_data;
        strobe   = 1'b1;
        repeat (4) @(negedge clk);
        strobe = 1'b0;
        // Let the synchroniser and the latch transfer settle
        repeat (12) @(negedge clk);
    endtask : send
endmodule : serial_host_model

// *** tb/synth_serial_latch_control_tb.sv ***
`timescale 1ns/10ps
`include "synth_latch_consts.svh"
module synth_serial_latch_control_tb
    import synth_latch_pkg::*;
;
    logic        clk = 1'b0;   // Core clock, 8 ns
    logic        rst_n;        // Active-low reset
    logic        pwr_en;       // Power enable pin
    logic        pd_tick;      // Comparison cycle pulse
    wire         sd, sc, le;   // Serial pins from the host model
    wire         cnt_rst, highz, pdown, hgain, qtr, damp, lockp;
    wire  [12:0] main_c;       // Main count field
    wire  [4:0]  swal;         // Swallow count field
    wire  [13:0] ratio;        // Reference ratio field
    wire  [20:0] ref_l;        // Reference latch image
    wire  [20:0] feed_l;       // Feedback latch image
    wire  [20:0] func_l;       // Function latch image
    wire         dampoe;       // Damping pin enable
    logic        clk_en;       // Clock enable
    int          err_count, compares, pulses, cyc;
    logic        prev_p = 1'b0; // Last sampled reset-pulse level

    always #4 clk = ~clk;

    serial_host_model i_serial_host_model (.clk(clk), .ser_data(sd),
        .ser_clk(sc), .strobe(le));

    synth_serial_latch_control i_synth_serial_latch_control (
        .CORE_CLK(clk), .RSTN(rst_n), .CLK_EN(clk_en), .SER_DATA(sd),
        .SER_CLK(sc), .WORD_LATCH_STROBE(le), .POWER_ENABLE(pwr_en),
        .PD_TICK(pd_tick), .REF_LATCH(ref_l), .FEED_LATCH(feed_l),
        .FUNC_LATCH(func_l),
        .COUNTER_RESET(cnt_rst), .PUMP_HIGHZ(highz), .POWERDOWN(pdown),
        .HIGH_GAIN(hgain), .QUARTER_RATIO(qtr),
        .DAMPING_SWITCH_OUTPUT(damp), .DAMPING_SWITCH_OE(dampoe),
        .MAIN_COUNT(main_c), .SWALLOW_COUNT(swal), .REF_RATIO(ratio),
        .LOCK_PRECISION(lockp));

    // Count reset pulses (counters and pump together); cut a hang short
    // Sampled on the falling edge, where the registered outputs are settled
    always @(negedge clk) begin
        cyc++;
        if ((cnt_rst & highz) === 1'b1 && prev_p !== 1'b1) pulses++;
        prev_p = cnt_rst & highz;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    // Word from bits 19..1 of a field image plus the two select bits
    function automatic word_t w(input logic [19:0] d, input logic [1:0] c);
        return {d[19:1], c};
    endfunction : w

    task automatic chk(input logic [31:0] got, exp, input string m);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    task automatic tx(input word_t x);
        i_serial_host_model.send(x);
    endtask : tx

    // Phase detector ticks, one core cycle wide, three apart
    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk) pd_tick = 1'b1;
            @(negedge clk) pd_tick = 1'b0;
            @(negedge clk);
        end
    endtask : tick

    // Init, reference, feedback, feedback again
    task automatic t_init();
        int p;
        p = pulses;
        tx(w(20'h00000, `DEST_INIT));
        chk(pulses - p, 1, "init pulse");
        tx(w(20'h80064, `DEST_REF));
        chk(pulses - p, 1, "ref gave pulse");
        chk(ratio, 14'h0032, "ref ratio");
        chk(lockp, 1'b1, "lock precision");
        tx(w(20'h0251C, `DEST_FEED));
        chk(pulses - p, 2, "first feedback pulse");
        chk(main_c, 13'h0094, "main count");
        chk(swal, 5'h0E, "swallow count");
        chk(feed_l, w(20'h0251C, `DEST_FEED), "feed latch");
        tx(w(20'h000FE, `DEST_FEED));
        chk(pulses - p, 2, "later feedback pulse");
        chk({main_c, swal}, {13'h0003, 5'h1F}, "min main");
    endtask : t_init

    // Hold bit set with powerdown bits: hold but no powerdown
    task automatic t_hold();
        tx(w(20'h40006, `DEST_FUNC));
        chk(func_l, w(20'h40006, `DEST_FUNC), "func latch");
        chk({cnt_rst, highz}, 2'h3, "hold level");
        chk(pdown, 1'b0, "hold powerdown");
        tx(w(20'h80064, `DEST_REF));
        tx(w(20'h000FE, `DEST_FEED));
        tx(w(20'h00000, `DEST_FUNC));
        chk({cnt_rst, highz}, 2'h0, "hold release");
    endtask : t_hold

    // Init with both powerdown bits starts synchronous powerdown
    task automatic t_syncpd();
        tx(w(20'h40004, `DEST_INIT));
        chk(pdown, 1'b1, "sync powerdown");
        tx(w(20'h00000, `DEST_FUNC));
        chk(pdown, 1'b0, "sync powerdown exit");
    endtask : t_syncpd

    // Loads while the pin holds powerdown; contents survive re-enable
    task automatic t_pin();
        @(negedge clk) pwr_en = 1'b0;
        repeat (8) @(negedge clk);
        chk(pdown, 1'b1, "pin powerdown");
        tx(w(20'h07FFE, `DEST_REF));
        chk({lockp, ratio}, {1'b0, 14'h3FFF}, "load in pd");
        chk(ref_l, w(20'h07FFE, `DEST_REF), "ref latch");
        pwr_en = 1'b1;
        // Bias settles within about 1 us after enable; wait it out
        repeat (125) @(negedge clk);
        chk({pdown, cnt_rst}, 2'h0, "re-enable");
        chk({ratio, main_c}, {14'h3FFF, 13'h0003}, "kept");
    endtask : t_pin

    // Clock enable low freezes the block; a word sent then is ignored
    task automatic t_freeze();
        @(negedge clk) clk_en = 1'b0;
        tx(w(20'h00002, `DEST_REF));
        chk(ratio, 14'h3FFF, "frozen");
        clk_en = 1'b1;
        repeat (4) @(negedge clk);
    endtask : t_freeze

    // Held high gain (q picks quarter ratio), then bit 8 low
    task automatic t_gain(input logic q);
        tx(w({10'h000, q, 9'h100}, `DEST_FUNC));
        tx(w(20'h800C0, `DEST_FEED));
        tick(20);
        chk({hgain, qtr}, {1'b1, q}, "held gain");
        tx(w(20'h000C0, `DEST_FEED));
        chk({hgain, qtr}, 2'h0, "gain cleared");
        tx(w(20'h00200, `DEST_FUNC));
        tx(w(20'h800C0, `DEST_FEED));
        chk({dampoe, damp, hgain}, 3'h7, "bit 8 low");
        tx(w(20'h000C0, `DEST_FEED));
        chk(hgain, 1'b0, "bit 8 low cur");
    endtask : t_gain

    // Timed gain lasts 4*s+3 ticks
    task automatic t_timed(input logic [3:0] s, input logic q);
        tx(w({5'h00, s, 1'b1, q, 9'h100}, `DEST_FUNC));
        tx(w(20'h800C0, `DEST_FEED));
        tick(4 * s + 2);
        chk({hgain, qtr}, {1'b1, q}, "timed gain on");
        tick(1);
        repeat (4) @(negedge clk);
        chk({hgain, qtr}, 2'h0, "timed gain off");
    endtask : t_timed

    task automatic stop_test();
        $display("Errors %0d of %0d comparisons", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        rst_n   = 1'b0;
        clk_en  = 1'b1;
        pwr_en  = 1'b1;
        pd_tick = 1'b0;
        repeat (4) @(negedge clk);
        chk({pdown, cnt_rst}, 2'h3, "reset levels");
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_init();
        t_hold();
        t_syncpd();
        t_pin();
        t_freeze();
        t_gain(1'b0);
        t_gain(1'b1);
        t_timed(4'h0, 1'b0);
        t_timed(4'h1, 1'b1);
        t_timed(4'hF, 1'b0);
        stop_test();
    end
endmodule : synth_serial_latch_control_tb
